/* rtl/ssc_config_regs.sv */
// Operation
// - soft reset bit resets chip and registers
// - soft reset bit clears itself
// - ascend bit picks step direction, default up
// - serial output indicator always reads one
// - reads return on dedicated serial output
// - mode field: zero normal, three power-down
// - device class field returns fixed code
// - part code field returns fixed code
// - hold bit keeps streaming address constant
module ssc_config_regs import ssc_pkg::*; #(
   parameter logic [3:0] CLASS_CODE = 4'h6, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h5a3c, // arbitrary value
   parameter logic [15:0] MAKER_CODE = 16'h1e77 // arbitrary value
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic spi_sclk,
   input wire logic spi_cs_b,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic [1:0] op_mode,
   output logic power_down,
   output logic reset_busy
);
   ssc_ser_if ser ();

   logic [7:0] cfg_reg;
   logic [7:0] mode_reg;
   logic [3:0] class_rsv;
   logic [7:0] stream_reg;
   logic [14:0] cur_addr;
   logic [6:0] rst_cnt;
   logic busy;
   wire core_rst_b;
   wire wr_en;
   wire soft_hit;
   wire bank_rst;
   wire hold;
   wire ascend;
   wire [7:0] cfg_rd;
   wire [7:0] class_rd;

   // the whole serial side is held while the soft reset runs
   assign core_rst_b = rst_b & ~busy;

   ssc_serial u_serial (
      .ref_clk(ref_clk),
      .rst_b(core_rst_b),
      .sclk_pin(spi_sclk),
      .cs_b_pin(spi_cs_b),
      .sdi_pin(spi_sdi),
      .sdo(spi_sdo),
      .ser(ser)
   );

   // write decode
   assign wr_en = ser.byte_done & ~ser.rnw;
   assign soft_hit = wr_en & (cur_addr == ADDR_CFG) & ser.byte_data[CFG_SOFT_RST_BIT];
   assign bank_rst = ~core_rst_b | soft_hit;
   assign hold = stream_reg[STREAM_HOLD_BIT];
   assign ascend = cfg_reg[CFG_ASCEND_BIT];

   // quiet-period counter ends the reset by itself
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         busy <= 1'b0;
         rst_cnt <= '0;
      end else if (soft_hit) begin
         busy <= 1'b1;
         rst_cnt <= SOFT_RST_LOAD;
      end else if (busy) begin
         if (rst_cnt == 7'h00) begin
            busy <= 1'b0;
         end else begin
            rst_cnt <= 7'(rst_cnt - 7'd1);
         end
      end
   end

   // register writes, all returned to defaults on soft reset
   always_ff @(posedge ref_clk) begin
      if (bank_rst) begin
         cfg_reg <= CFG_RESET & CFG_WR_MASK;
         mode_reg <= MODE_RESET;
         class_rsv <= CLASS_RSV_RESET;
         stream_reg <= STREAM_RESET;
      end else if (wr_en) begin
         if (cur_addr == ADDR_CFG) begin
            cfg_reg <= ser.byte_data & CFG_WR_MASK;
         end
         if (cur_addr == ADDR_MODE) begin
            mode_reg <= ser.byte_data;
         end
         if (cur_addr == ADDR_CLASS) begin
            class_rsv <= ser.byte_data[7:4];
         end
         if (cur_addr == ADDR_STREAM) begin
            stream_reg <= ser.byte_data;
         end
      end
   end

   // header loads the address, each full byte then steps it unless the hold bit is set
   always_ff @(posedge ref_clk) begin
      if (bank_rst) begin
         cur_addr <= '0;
      end else if (ser.hdr_valid) begin
         cur_addr <= ser.hdr_addr;
      end else if (ser.byte_done && !hold) begin
         cur_addr <= ascend ? 15'(cur_addr + 15'd1) : 15'(cur_addr - 15'd1);
      end
   end

   // indicator forced to one, soft reset bit reads zero
   assign cfg_rd = (cfg_reg & CFG_WR_MASK) | CFG_SDO_ONE;
   // fixed class code under writable reserved nibble
   assign class_rd = {class_rsv, CLASS_CODE};

   // read mux, unmapped addresses read zero
   assign ser.rd_byte = (cur_addr == ADDR_CFG) ? cfg_rd :
      (cur_addr == ADDR_MODE) ? mode_reg :
      (cur_addr == ADDR_CLASS) ? class_rd :
      (cur_addr == ADDR_PART_LO) ? PART_CODE[7:0] :
      (cur_addr == ADDR_PART_HI) ? PART_CODE[15:8] :
      (cur_addr == ADDR_MAKER_LO) ? MAKER_CODE[7:0] :
      (cur_addr == ADDR_MAKER_HI) ? MAKER_CODE[15:8] :
      (cur_addr == ADDR_STREAM) ? stream_reg : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (!core_rst_b) begin
         op_mode <= MODE_NORMAL;
         power_down <= 1'b0;
      end else begin
         op_mode <= mode_reg[1:0];
         power_down <= (mode_reg[1:0] == MODE_PD);
      end
   end

   assign reset_busy = busy;

   property p_soft_reset;
      @(posedge ref_clk) disable iff (!rst_b)
      soft_hit |=> busy && (mode_reg == MODE_RESET) && (stream_reg == STREAM_RESET)
         && (cfg_rd == CFG_RESET);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

   property p_self_clear;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(busy) |-> ##93 busy ##1 !busy;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("soft reset length wrong");

   property p_ascend;
      @(posedge ref_clk) disable iff (!rst_b)
      ser.byte_done && !soft_hit && !hold |=>
         cur_addr == ($past(ascend) ? 15'($past(cur_addr) + 15'd1)
         : 15'($past(cur_addr) - 15'd1));
   endproperty
   a_ascend: assert property (p_ascend) else $error("address step wrong");

   property p_sdo_one;
      @(posedge ref_clk) disable iff (!rst_b)
      cur_addr == ADDR_CFG |-> ser.rd_byte[CFG_SDO_BIT] && !ser.rd_byte[CFG_SOFT_RST_BIT];
   endproperty
   a_sdo_one: assert property (p_sdo_one) else $error("config readback wrong");

   property p_mode;
      @(posedge ref_clk) disable iff (!core_rst_b)
      ##1 power_down == ($past(mode_reg[1:0]) == MODE_PD);
   endproperty
   a_mode: assert property (p_mode) else $error("power down mismatch");

   property p_class;
      @(posedge ref_clk) disable iff (!rst_b)
      cur_addr == ADDR_CLASS |-> ser.rd_byte[3:0] == CLASS_CODE;
   endproperty
   a_class: assert property (p_class) else $error("class code wrong");

   property p_part;
      @(posedge ref_clk) disable iff (!rst_b)
      cur_addr == ADDR_PART_HI |-> ser.rd_byte == PART_CODE[15:8];
   endproperty
   a_part: assert property (p_part) else $error("part code wrong");

   property p_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      ser.byte_done && hold && !soft_hit |=> $stable(cur_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("held address moved");

   property p_header;
      @(posedge ref_clk) disable iff (!core_rst_b)
      ser.hdr_valid |=> cur_addr == $past(ser.hdr_addr);
   endproperty
   a_header: assert property (p_header) else $error("header address lost");

   property p_part_lo;
      @(posedge ref_clk) disable iff (!rst_b)
      cur_addr == ADDR_PART_LO |-> ser.rd_byte == PART_CODE[7:0];
   endproperty
   a_part_lo: assert property (p_part_lo) else $error("part code low byte wrong");

   property p_op_copy;
      @(posedge ref_clk) disable iff (!core_rst_b)
      ##1 op_mode == $past(mode_reg[1:0]);
   endproperty
   a_op_copy: assert property (p_op_copy) else $error("mode output mismatch");

   property p_busy_quiet;
      @(posedge ref_clk) disable iff (!rst_b)
      busy |-> !ser.hdr_valid && !ser.byte_done;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("frame during soft reset");

   property p_ascend_wr;
      @(posedge ref_clk) disable iff (!rst_b)
      wr_en && (cur_addr == ADDR_CFG) && !soft_hit |=>
         ascend == $past(ser.byte_data[CFG_ASCEND_BIT]);
   endproperty
   a_ascend_wr: assert property (p_ascend_wr) else $error("direction bit not stored");
endmodule // ssc_config_regs

/* rtl/ssc_pkg.sv */
package ssc_pkg;
   // register byte addresses, 15-bit serial address space
   localparam logic [14:0] ADDR_CFG = 15'h0000;
   localparam logic [14:0] ADDR_MODE = 15'h0002;
   localparam logic [14:0] ADDR_CLASS = 15'h0003;
   localparam logic [14:0] ADDR_PART_LO = 15'h0004;
   localparam logic [14:0] ADDR_PART_HI = 15'h0005;
   localparam logic [14:0] ADDR_MAKER_LO = 15'h000c;
   localparam logic [14:0] ADDR_MAKER_HI = 15'h000d;
   localparam logic [14:0] ADDR_STREAM = 15'h0010;

   // interface_config fields
   localparam int CFG_SOFT_RST_BIT = 7;
   localparam int CFG_ASCEND_BIT = 5;
   localparam int CFG_SDO_BIT = 4;
   localparam logic [7:0] CFG_RESET = 8'h30;
   localparam logic [7:0] CFG_WR_MASK = 8'h6f;
   localparam logic [7:0] CFG_SDO_ONE = 8'h10;

   // device_operating_mode, device_class, streaming_address_control
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PD = 2'h3;
   localparam logic [3:0] CLASS_RSV_RESET = 4'h0;
   localparam logic [7:0] STREAM_RESET = 8'h00;
   localparam int STREAM_HOLD_BIT = 0;

   // serial framing
   localparam logic [4:0] HDR_BITS = 5'd16;
   localparam int PIN_SDI = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_CS = 2;
   localparam logic [2:0] PIN_IDLE = 3'h4;

   // soft reset quiet period
   localparam int SOFT_RST_NS = 750;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] SOFT_RST_LOAD = 7'(SOFT_RST_CYC - 1);
endpackage

/* rtl/ssc_ser_if.sv */
interface ssc_ser_if;
   logic hdr_valid;
   logic rnw;
   logic [14:0] hdr_addr;
   logic byte_done;
   logic [7:0] byte_data;
   logic [7:0] rd_byte;
   modport front (output hdr_valid, output rnw, output hdr_addr, output byte_done,
      output byte_data, input rd_byte);
   modport bank (input hdr_valid, input rnw, input hdr_addr, input byte_done,
      input byte_data, output rd_byte);
endinterface

/* rtl/ssc_serial.sv */
module ssc_serial import ssc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic sclk_pin,
   input wire logic cs_b_pin,
   input wire logic sdi_pin,
   output logic sdo,
   ssc_ser_if.front ser
);
   logic [2:0] pin_in;
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] filt;
   logic [2:0] filt_d;
   logic [14:0] sh;
   logic [4:0] hcnt;
   logic [2:0] bcnt;
   logic load_pend;
   logic [7:0] sdo_sh;
   wire sel;
   wire rise;
   wire fall;

   assign pin_in = {cs_b_pin, sclk_pin, sdi_pin};

   // three-stage sync, value taken once stages two and three agree
   genvar g;
   for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
         if (!rst_b) begin
            s1[g] <= PIN_IDLE[g];
            s2[g] <= PIN_IDLE[g];
            s3[g] <= PIN_IDLE[g];
            filt[g] <= PIN_IDLE[g];
         end else begin
            s1[g] <= pin_in[g];
            s2[g] <= s1[g];
            s3[g] <= s2[g];
            if (s2[g] == s3[g]) begin
               filt[g] <= s3[g];
            end
         end
      end
   end

   // clock edges seen only while selected
   assign sel = ~filt[PIN_CS];
   assign rise = sel & filt[PIN_SCLK] & ~filt_d[PIN_SCLK];
   assign fall = sel & ~filt[PIN_SCLK] & filt_d[PIN_SCLK];
   assign sdo = sdo_sh[7];

   // header of rnw plus 15 address bits, then data bytes msb first
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         filt_d <= PIN_IDLE;
         sh <= '0;
         hcnt <= '0;
         bcnt <= '0;
         load_pend <= 1'b0;
         sdo_sh <= '0;
         ser.hdr_valid <= 1'b0;
         ser.rnw <= 1'b0;
         ser.hdr_addr <= '0;
         ser.byte_done <= 1'b0;
         ser.byte_data <= '0;
      end else begin
         filt_d <= filt;
         ser.hdr_valid <= 1'b0;
         ser.byte_done <= 1'b0;
         if (!sel) begin
            hcnt <= '0;
            bcnt <= '0;
            load_pend <= 1'b0;
            sdo_sh <= '0;
         end else if (rise) begin
            sh <= {sh[13:0], filt[PIN_SDI]};
            if (hcnt != HDR_BITS) begin
               hcnt <= 5'(hcnt + 5'd1);
               if (hcnt == 5'(HDR_BITS - 5'd1)) begin
                  ser.hdr_valid <= 1'b1;
                  ser.rnw <= sh[14];
                  ser.hdr_addr <= {sh[13:0], filt[PIN_SDI]};
                  load_pend <= 1'b1;
               end
            end else begin
               bcnt <= 3'(bcnt + 3'd1);
               if (bcnt == 3'h7) begin
                  ser.byte_done <= 1'b1;
                  ser.byte_data <= {sh[6:0], filt[PIN_SDI]};
                  load_pend <= 1'b1;
               end
            end
         end else if (fall) begin
            if (load_pend) begin
               sdo_sh <= ser.rd_byte;
               load_pend <= 1'b0;
            end else begin
               sdo_sh <= {sdo_sh[6:0], 1'b0};
            end
         end
      end
   end
endmodule // ssc_serial

/* testbench/ssc_host_model.sv */
// serial host driving the configuration port, bit by bit
module ssc_host_model (
   input wire logic ref_clk,
   output logic sclk,
   output logic cs_b,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle pins: clock parked low, not selected
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      sdi = 1'b0;
   end

   // one bit: data set in the low phase, both phases six cycles long
   task automatic bit_io(input logic b, output logic r);
      @(posedge ref_clk);
      sclk <= 1'b0;
      sdi <= b;
      repeat (6) @(posedge ref_clk);
      r = sdo;
      sclk <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask

   // whole frame: direction, 15 address bits, then n bytes msb first
   task automatic frame(input logic rnw, input logic [14:0] addr, input int n,
      input logic [7:0] wd [4], output logic [7:0] rd [4]);
      logic r;
      rd = '{default: 8'h00};
      @(posedge ref_clk);
      cs_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
      bit_io(rnw, r);
      for (int i = 14; i >= 0; i--) begin
         bit_io(addr[i], r);
      end
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_io(wd[k][i], r);
            rd[k][i] = r;
         end
      end
      @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (6) @(posedge ref_clk);
      cs_b <= 1'b1;
      sdi <= ~sdi; // released data line does not keep its last value
      repeat (6) @(posedge ref_clk);
   endtask
endmodule // ssc_host_model

/* testbench/tb_top.sv */
module tb_top import ssc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] T_CLASS = 4'h9; // arbitrary value
   localparam logic [15:0] T_PART = 16'hc3a5; // arbitrary value
   localparam logic [15:0] T_MAKER = 16'h7e18; // arbitrary value

   logic ref_clk;
   logic rst_b;
   logic sclk;
   logic cs_b;
   logic sdi;
   logic sdo;
   logic [1:0] op_mode;
   logic power_down;
   logic reset_busy;
   int n_errors;
   int tests_run;
   int cyc;
   int busy_cnt;
   logic [7:0] wd [4];
   logic [7:0] rd [4];

   ssc_config_regs #(.CLASS_CODE(T_CLASS), .PART_CODE(T_PART), .MAKER_CODE(T_MAKER)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdi(sdi),
      .spi_sdo(sdo), .op_mode(op_mode), .power_down(power_down), .reset_busy(reset_busy));

   ssc_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));

   // clock
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   // cycle ceiling and quiet period length
   always @(posedge ref_clk) begin
      cyc++;
      if (reset_busy === 1'b1) begin
         busy_cnt++;
      end
      if (cyc == 40000) begin
         n_errors++;
         summarize();
      end
   end

   // verdict and end of run
   task automatic summarize;
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // byte compare
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single-byte write frame
   task automatic wr1(input logic [14:0] a, input logic [7:0] d);
      wd = '{d, 8'h00, 8'h00, 8'h00};
      host.frame(1'b0, a, 1, wd, rd);
   endtask

   // streaming read of n bytes, expected bytes packed first-byte high
   task automatic rd_chk(input logic [14:0] a, input int n, input logic [23:0] e);
      wd = '{default: 8'h00};
      host.frame(1'b1, a, n, wd, rd);
      for (int k = 0; k < n; k++) begin
         chk(rd[k], e[23 - 8 * k -: 8]);
      end
   endtask

   // main sequence
   initial begin
      n_errors = 0;
      tests_run = 0;
      cyc = 0;
      busy_cnt = 0;
      rst_b = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      // defaults and fixed codes, ascending stream
      rd_chk(ADDR_CFG, 1, 24'h300000);
      rd_chk(ADDR_CLASS, 3, {4'h0, T_CLASS, T_PART[7:0], T_PART[15:8]});
      rd_chk(ADDR_MAKER_LO, 2, {T_MAKER[7:0], T_MAKER[15:8], 8'h00});
      rd_chk(ADDR_STREAM, 1, 24'h000000);
      // unmapped place ignores writes and reads zero
      wr1(15'h0007, 8'ha5);
      rd_chk(15'h0007, 1, 24'h000000);
      // fixed codes ignore writes, reserved class nibble is stored
      wr1(ADDR_CLASS, 8'hff);
      wr1(ADDR_PART_LO, ~T_PART[7:0]);
      // indicator stays one, direction turned to descending
      wr1(ADDR_CFG, 8'h4a);
      rd_chk(ADDR_CFG, 1, 24'h5a0000);
      rd_chk(ADDR_PART_HI, 3, {T_PART[15:8], T_PART[7:0], 4'hf, T_CLASS});
      // every mode code
      for (int m = 0; m < 4; m++) begin
         wr1(ADDR_MODE, 8'(m));
         chk({6'h00, op_mode}, 8'(m));
         chk({7'h00, power_down}, {7'h00, 1'(m == 3)});
      end
      // address hold on a streaming write and read
      wr1(ADDR_STREAM, 8'h01);
      wd = '{8'h02, 8'h01, 8'h03, 8'h00};
      host.frame(1'b0, ADDR_MODE, 3, wd, rd);
      rd_chk(ADDR_MODE, 2, 24'h030300);
      rd_chk(ADDR_CLASS, 1, {4'hf, T_CLASS, 16'h0000});
      chk({7'h00, power_down}, 8'h01);
      // soft reset with other bits set
      busy_cnt = 0;
      wr1(ADDR_CFG, 8'hca);
      // no frame until quiet period ends
      for (int i = 0; i < 200 && reset_busy !== 1'b0; i++) begin
         @(posedge ref_clk);
      end
      chk(8'(busy_cnt), 8'(SOFT_RST_CYC));
      rd_chk(ADDR_CFG, 1, 24'h300000);
      rd_chk(ADDR_MODE, 1, 24'h000000);
      rd_chk(ADDR_STREAM, 1, 24'h000000);
      rd_chk(ADDR_CLASS, 1, {4'h0, T_CLASS, 16'h0000});
      chk({6'h00, op_mode}, 8'h00);
      chk({7'h00, power_down}, 8'h00);
      summarize();
   end
endmodule // tb_top
